// ==== ring_interface_unit.sv ====
// Dual ring node access: two access buffers, loopback selectors, DMA steering
`timescale 1ns/100ps
module ring_interface_unit #(
  parameter int unsigned TOKEN_TIMEOUT = ring_pkg::TOKEN_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  // Node identity and mode
  input  wire logic [ring_pkg::ADDR_W-1:0]   node_addr,
  input  wire logic                          active_ring,
  input  wire logic                          quarantined,
  input  wire logic                          isolated,
  input  wire logic                          loopback_en,
  input  wire logic                          token_track_en,
  // Ring inputs from each ring's upstream neighbour
  input  wire logic [1:0]                    rx_req,
  input  wire ring_pkg::ring_word_t [1:0]    rx_word,
  output      logic [1:0]                    rx_ack,
  // Ring outputs to each ring's downstream neighbour
  output      logic [1:0]                    tx_req,
  output      ring_pkg::ring_word_t [1:0]    tx_word,
  input  wire logic [1:0]                    tx_ack,
  // Upstream token seen and hold request toward upstream node
  input  wire logic [1:0]                    up_token_seen,
  output      logic [1:0]                    up_token_hold,
  // Receive DMA toward node processor memory
  output      logic                          rxd_valid,
  output      ring_pkg::ring_word_t          rxd_word,
  output      logic                          rxd_ring,
  input  wire logic                          rxd_ready,
  output      logic                          rxd_batch_done,
  // Transmit DMA from node processor memory
  input  wire logic                          txd_valid,
  input  wire ring_pkg::ring_word_t          txd_word,
  input  wire logic [ring_pkg::LEN_W-1:0]    txd_pending,
  output      logic                          txd_ready,
  output      logic                          txd_done,
  // Token supervision
  output      logic                          lost_token,
  input  wire logic                          lost_token_clr,
  output      logic [1:0]                    token_tracking_flag
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic is_kind(input ring_pkg::ring_word_t w, input logic [1:0] k);
    return w.kind == k;
  endfunction

  // Ring 0 neighbour order ascends, ring 1 descends
  function automatic logic [ring_pkg::ADDR_W-1:0] next_addr(input logic ring,
                                                         input logic [ring_pkg::ADDR_W-1:0] a);
    return ring ? a - 1'b1 : a + 1'b1;
  endfunction

  // ------------------------------------------------------------
  // Access buffers and loopback selectors
  // ------------------------------------------------------------
  logic [1:0]                 buf_full;
  logic [1:0]                 buf_out_req;
  ring_pkg::ring_word_t [1:0] buf_word;
  logic [1:0]                 buf_out_ack;
  logic [1:0]                 fwd_req;
  logic [1:0]                 take_local;
  logic [1:0]                 sel_req;
  ring_pkg::ring_word_t [1:0] sel_word;
  logic [1:0]                 ins_req;
  logic [1:0]                 own_msg;
  logic [1:0]                 in_own_r;
  logic [1:0]                 in_own_nxt;
  logic                       tx_ring;
  logic                       rxd_sel;

  assign tx_ring = active_ring;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ring
      ring_access_buffer u_buf (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .in_req   (rx_req[g]),
        .in_word  (rx_word[g]),
        .in_ack   (rx_ack[g]),
        .hold     (1'b0),
        .out_req  (buf_out_req[g]),
        .out_word (buf_word[g]),
        .out_ack  (buf_out_ack[g]),
        .full     (buf_full[g])
      );

      // Addressed to this node: any non-token word with matching dest or its continuation, on either ring, not quarantined
      assign own_msg[g] = buf_out_req[g] && !is_kind(buf_word[g], ring_pkg::KIND_TOKEN)
                        && (buf_word[g].sop ? buf_word[g].dest == node_addr : in_own_r[g]);
      assign take_local[g] = own_msg[g] && !quarantined;
      assign fwd_req[g]    = buf_out_req[g] && !take_local[g];

      // Insertion enters the active ring's selector only; loopback sends it out on the other ring
      assign ins_req[g] = (tx_ring == 1'(g)) && txd_valid && txd_ready;
    end
  endgenerate

  always_comb begin
    in_own_nxt = in_own_r;
    for (int i = 0; i < 2; i++) begin
      if (buf_out_req[i] && buf_out_ack[i]) begin
        in_own_nxt[i] = own_msg[i] && !buf_word[i].eop;
      end
    end
  end

  // Selectors: loopback feeds each ring's traffic back into the other
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      sel_req[i]  = fwd_req[i];
      sel_word[i] = buf_word[i];
      if (ins_req[i] && !fwd_req[i]) begin
        sel_req[i]  = 1'b1;
        sel_word[i] = txd_word;
      end
    end
    if (loopback_en) begin
      sel_req  = {sel_req[0], sel_req[1]};
      sel_word = {sel_word[0], sel_word[1]};
    end
  end

  assign tx_req  = sel_req;
  assign tx_word = sel_word;

  // Buffer acks route back through the selector to the buffer that drove that output; insertion uses tx_ack of the active ring without the swap
  logic [1:0] out_ack_eff;
  assign out_ack_eff = loopback_en ? {tx_ack[0], tx_ack[1]} : tx_ack;
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      buf_out_ack[i] = take_local[i] ? (rxd_ready && rxd_sel == i[0]) : out_ack_eff[i];
    end
  end

  // ------------------------------------------------------------
  // Receive DMA steering
  // ------------------------------------------------------------
  logic rx_busy_r;
  logic rx_busy_nxt;
  ring_pkg::ring_word_t rxd_word_r;
  logic rxd_ring_r;
  logic rxd_valid_r;
  logic rxd_batch_r;
  ring_pkg::ring_word_t rxd_word_nxt;
  logic rxd_ring_nxt;
  logic rxd_valid_nxt;
  logic rxd_batch_nxt;

  assign rxd_sel = take_local[0] ? 1'b0 : 1'b1;

  always_comb begin
    rxd_word_nxt  = rxd_word_r;
    rxd_ring_nxt  = rxd_ring_r;
    rxd_valid_nxt = 1'b0;
    rxd_batch_nxt = 1'b0;
    rx_busy_nxt   = rx_busy_r;
    if ((take_local[0] || take_local[1]) && rxd_ready) begin
      rxd_valid_nxt = 1'b1;
      rxd_word_nxt  = buf_word[rxd_sel];
      rxd_ring_nxt  = rxd_sel;
      rx_busy_nxt   = 1'b1;
    end else if (rx_busy_r && !(buf_full[0] || buf_full[1])) begin
      // Back-to-back run ended: hand the batch to distribution
      rxd_batch_nxt = 1'b1;
      rx_busy_nxt   = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rxd_word_r  <= '0;
      rxd_ring_r  <= 1'b0;
      rxd_valid_r <= 1'b0;
      rxd_batch_r <= 1'b0;
      rx_busy_r   <= 1'b0;
      in_own_r    <= 2'b00;
    end else begin
      rxd_word_r  <= rxd_word_nxt;
      rxd_ring_r  <= rxd_ring_nxt;
      rxd_valid_r <= rxd_valid_nxt;
      rxd_batch_r <= rxd_batch_nxt;
      rx_busy_r   <= rx_busy_nxt;
      in_own_r    <= in_own_nxt;
    end
  end

  assign rxd_valid      = rxd_valid_r;
  assign rxd_word       = rxd_word_r;
  assign rxd_ring       = rxd_ring_r;
  assign rxd_batch_done = rxd_batch_r;

  // ------------------------------------------------------------
  // Transmit: wait for upstream token, hold, insert, release
  // ------------------------------------------------------------
  ring_pkg::tx_state_t tx_st_r;
  ring_pkg::tx_state_t tx_st_nxt;
  logic [ring_pkg::LEN_W-1:0] blk_cnt_r;
  logic [ring_pkg::LEN_W-1:0] blk_cnt_nxt;
  logic txd_done_r;
  logic txd_done_nxt;
  logic may_send;
  logic user_ok;

  // Isolated nodes send maintenance words only
  assign user_ok  = !isolated;
  assign may_send = !quarantined && txd_pending != '0
                 && (user_ok || is_kind(txd_word, ring_pkg::KIND_MAINT));

  always_comb begin
    tx_st_nxt    = tx_st_r;
    blk_cnt_nxt  = blk_cnt_r;
    txd_done_nxt = 1'b0;
    case (tx_st_r)
      ring_pkg::TX_IDLE: begin
        if (up_token_seen[tx_ring] && may_send) begin
          tx_st_nxt   = ring_pkg::TX_SEND;
          blk_cnt_nxt = '0;
        end
      end
      ring_pkg::TX_SEND: begin
        if (txd_valid && txd_ready && tx_ack[tx_ring]) begin
          blk_cnt_nxt = blk_cnt_r + 1'b1;
          // Block ends at maximum size or when the queue empties
          if (blk_cnt_r == ring_pkg::LEN_W'(ring_pkg::MAX_MSG_WORDS - 1)
              || (txd_word.eop && txd_pending == ring_pkg::LEN_W'(1))) begin
            tx_st_nxt    = ring_pkg::TX_DONE;
            txd_done_nxt = 1'b1;
          end
        end
      end
      ring_pkg::TX_DONE: begin
        tx_st_nxt = ring_pkg::TX_IDLE;
      end
      default: tx_st_nxt = ring_pkg::TX_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tx_st_r    <= ring_pkg::TX_IDLE;
      blk_cnt_r  <= '0;
      txd_done_r <= 1'b0;
    end else begin
      tx_st_r    <= tx_st_nxt;
      blk_cnt_r  <= blk_cnt_nxt;
      txd_done_r <= txd_done_nxt;
    end
  end

  // Token stays held upstream through insertion and done signalling
  always_comb begin
    up_token_hold = 2'b00;
    if (tx_st_r != ring_pkg::TX_IDLE) begin
      up_token_hold[tx_ring] = 1'b1;
    end
  end
  assign txd_ready = (tx_st_r == ring_pkg::TX_SEND) && !fwd_req[tx_ring]
                   && (user_ok || is_kind(txd_word, ring_pkg::KIND_MAINT));
  assign txd_done  = txd_done_r;

  // ------------------------------------------------------------
  // Token supervision
  // ------------------------------------------------------------
  logic [31:0] tok_cnt_r;
  logic [31:0] tok_cnt_nxt;
  logic        lost_r;
  logic        lost_nxt;
  logic [1:0]  ttf_r;
  logic [1:0]  ttf_nxt;
  logic [1:0]  tok_pass;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      tok_pass[i] = buf_out_req[i] && buf_out_ack[i] && is_kind(buf_word[i], ring_pkg::KIND_TOKEN);
    end
    tok_cnt_nxt = tok_pass[tx_ring] ? 32'h0000_0000 : tok_cnt_r + 32'h0000_0001;
    lost_nxt    = lost_r;
    if (lost_token_clr) begin
      lost_nxt = 1'b0;
    end
    if (tok_cnt_r == TOKEN_TIMEOUT[31:0]) begin
      lost_nxt = 1'b1;
    end
    ttf_nxt = ttf_r;
    for (int i = 0; i < 2; i++) begin
      if (!token_track_en) begin
        ttf_nxt[i] = 1'b0;
      end else if (tok_pass[i]) begin
        ttf_nxt[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tok_cnt_r <= 32'h0000_0000;
      lost_r    <= 1'b0;
      ttf_r     <= 2'b00;
    end else begin
      tok_cnt_r <= tok_cnt_nxt;
      lost_r    <= lost_nxt;
      ttf_r     <= ttf_nxt;
    end
  end

  assign lost_token          = lost_r;
  assign token_tracking_flag = ttf_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  quar_no_rx_a: assert property (quarantined |=> !rxd_valid)
    else $error("quarantined node delivered a word");
  quar_no_send_a: assert property (quarantined && tx_st_r == ring_pkg::TX_IDLE |=> tx_st_r == ring_pkg::TX_IDLE)
    else $error("quarantined node started sending");
  own_rx_dma_a: assert property (take_local[0] && rxd_ready |=> rxd_valid && !rxd_ring)
    else $error("own message not sent to memory");
  fwd_unchanged_a: assert property (fwd_req[0] && !loopback_en |-> tx_req[0] && tx_word[0] == buf_word[0])
    else $error("foreign message altered");
  hold_while_send_a: assert property (tx_st_r == ring_pkg::TX_SEND |-> up_token_hold[tx_ring])
    else $error("token released during insertion");
  wait_token_a: assert property (tx_st_r == ring_pkg::TX_IDLE && !up_token_seen[tx_ring] |=> tx_st_r != ring_pkg::TX_SEND)
    else $error("insert started without token");
  block_size_a: assert property (tx_st_r == ring_pkg::TX_SEND |-> blk_cnt_r < ring_pkg::LEN_W'(ring_pkg::MAX_MSG_WORDS))
    else $error("block exceeded maximum size");
  done_then_release_a: assert property (txd_done |-> up_token_hold[tx_ring] ##1 !up_token_hold[tx_ring])
    else $error("token released before done");
  loop_swap_a: assert property (loopback_en |-> tx_req[1] == (fwd_req[0] || ins_req[0]))
    else $error("loopback did not redirect ring");
  iso_maint_a: assert property (isolated && txd_ready |-> is_kind(txd_word, ring_pkg::KIND_MAINT))
    else $error("isolated node sent traffic");
  lost_set_a: assert property (tok_cnt_r == TOKEN_TIMEOUT[31:0] |=> lost_token)
    else $error("lost token not flagged");

  rx_own_c: cover property (rxd_valid ##1 rxd_batch_done);
  tx_block_c: cover property (tx_st_r == ring_pkg::TX_SEND ##[1:20] txd_done);
  loop_c: cover property (loopback_en && tx_req[1]);

endmodule

// ==== ring_pkg.sv ====
// Shared types and constants for the dual ring node access block
package ring_pkg;

  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned DATA_W        = 32;
  localparam int unsigned CHAN_W        = 4;
  // Largest message in words, shared by every node on the ring
  localparam int unsigned MAX_MSG_WORDS = 16;
  localparam int unsigned LEN_W         = 16;
  // Token absence timeout
  localparam int unsigned TOKEN_TIMEOUT_US = 100;
  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned TOKEN_TIMEOUT_CYC = TOKEN_TIMEOUT_US * CLK_MHZ;

  localparam logic [1:0] KIND_DATA  = 2'h0;
  localparam logic [1:0] KIND_TOKEN = 2'h1;
  localparam logic [1:0] KIND_MAINT = 2'h2;

  // One ring word with its framing
  typedef struct packed {
    logic [1:0]        kind;
    logic              sop;
    logic              eop;
    logic [ADDR_W-1:0] dest;
    logic [CHAN_W-1:0] chan;
    logic [DATA_W-1:0] data;
  } ring_word_t;

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_SEND,
    TX_DONE
  } tx_state_t;

endpackage

// ==== ring_access_buffer.sv ====
// One-word ring access buffer with request/acknowledge handshake both sides
`timescale 1ns/100ps
module ring_access_buffer (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // Upstream side
  input  wire logic              in_req,
  input  wire ring_pkg::ring_word_t in_word,
  output      logic              in_ack,
  // Hold the word in place
  input  wire logic              hold,
  // Downstream side
  output      logic              out_req,
  output      ring_pkg::ring_word_t out_word,
  input  wire logic              out_ack,
  // Held word view
  output      logic              full
);

  logic                 full_r;
  logic                 full_nxt;
  ring_pkg::ring_word_t word_r;
  ring_pkg::ring_word_t word_nxt;

  always_comb begin
    full_nxt = full_r;
    word_nxt = word_r;
    if (full_r && out_ack && !hold) begin
      full_nxt = 1'b0;
    end
    if (in_req && in_ack) begin
      full_nxt = 1'b1;
      word_nxt = in_word;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      full_r <= 1'b0;
      word_r <= '0;
    end else begin
      full_r <= full_nxt;
      word_r <= word_nxt;
    end
  end

  assign in_ack   = !full_r || (out_ack && !hold);
  assign out_req  = full_r && !hold;
  assign out_word = word_r;
  assign full     = full_r;

endmodule

// ==== ring_neighbor_model.sv ====
// Downstream neighbour model: acknowledges and logs each ring's output words
`timescale 1ns/100ps
module ring_neighbor_model (
  // Clock
  input  wire logic                       sys_clk,
  // Pace control, high for a slow neighbour
  input  wire logic                       slow,
  // Ring outputs of the node under test
  input  wire logic [1:0]                 tx_req,
  input  wire ring_pkg::ring_word_t [1:0] tx_word,
  output      logic [1:0]                 tx_ack
);
  ring_pkg::ring_word_t got0[$];
  ring_pkg::ring_word_t got1[$];
  logic                 phase_r = 1'b0;

  // Acks only a standing request; the slow pace acks every other cycle
  assign tx_ack = tx_req & {2{~slow | phase_r}};

  always @(posedge sys_clk) begin
    phase_r <= ~phase_r;
    if (tx_req[0] && tx_ack[0]) begin
      got0.push_back(tx_word[0]);
    end
    if (tx_req[1] && tx_ack[1]) begin
      got1.push_back(tx_word[1]);
    end
  end
endmodule

// ==== dual_token_ring_node_access_bench.sv ====
// Self-checking bench for the dual ring node access block
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
  $display("BAD t=%0t got %0h want %0h", $time, (a), (b)); end end
module dual_token_ring_node_access_bench;
  localparam int unsigned TMO = 50;
  localparam logic [7:0]  ME  = 8'h5a;
  logic                        sys_clk = 1'b0;
  logic                        rst_n, quarantined, isolated, loopback_en, token_track_en;
  logic                        active_ring, rxd_ready, txd_valid, lost_token_clr, slow;
  logic                        rxd_valid, rxd_ring, rxd_batch_done, txd_ready, txd_done;
  logic                        lost_token;
  logic [ring_pkg::ADDR_W-1:0] node_addr;
  logic [1:0]                  rx_req, rx_ack, tx_req, tx_ack, up_token_seen, up_token_hold;
  logic [1:0]                  token_tracking_flag;
  ring_pkg::ring_word_t [1:0]  rx_word, tx_word;
  ring_pkg::ring_word_t        rxd_word, txd_word;
  logic [ring_pkg::LEN_W-1:0]  txd_pending;
  ring_pkg::ring_word_t        rxq[$];
  logic                        ringq[$];
  int                          fail_count = 0, tests_run = 0, batch_sz = 0;

  always #2.5 sys_clk = ~sys_clk;

  ring_interface_unit #(.TOKEN_TIMEOUT(TMO)) dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .node_addr(node_addr), .active_ring(active_ring),
    .quarantined(quarantined), .isolated(isolated), .loopback_en(loopback_en),
    .token_track_en(token_track_en), .rx_req(rx_req), .rx_word(rx_word), .rx_ack(rx_ack),
    .tx_req(tx_req), .tx_word(tx_word), .tx_ack(tx_ack), .up_token_seen(up_token_seen),
    .up_token_hold(up_token_hold), .rxd_valid(rxd_valid), .rxd_word(rxd_word),
    .rxd_ring(rxd_ring), .rxd_ready(rxd_ready), .rxd_batch_done(rxd_batch_done),
    .txd_valid(txd_valid), .txd_word(txd_word), .txd_pending(txd_pending),
    .txd_ready(txd_ready), .txd_done(txd_done), .lost_token(lost_token),
    .lost_token_clr(lost_token_clr), .token_tracking_flag(token_tracking_flag));

  ring_neighbor_model m (.sys_clk(sys_clk), .slow(slow), .tx_req(tx_req), .tx_word(tx_word),
    .tx_ack(tx_ack));

  // Receive DMA monitor; one-cycle pulses are logged where they stand
  always @(posedge sys_clk) begin
    if (rxd_valid === 1'b1) begin
      rxq.push_back(rxd_word);
      ringq.push_back(rxd_ring);
    end
    if (rxd_batch_done === 1'b1) begin
      batch_sz = rxq.size();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic ring_pkg::ring_word_t mk(logic [1:0] kind, logic sop, logic eop,
                                              logic [7:0] dest, logic [31:0] data);
    return '{kind, sop, eop, dest, 4'h3, data};
  endfunction

  function automatic int gsz(int o);
    return o ? m.got1.size() : m.got0.size();
  endfunction

  function automatic ring_pkg::ring_word_t last(int o);
    return o ? m.got1[$] : m.got0[$];
  endfunction

  task automatic step;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic complete_run;
    $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic give_up;
    fail_count++;
    complete_run();
  endtask

  // Holds request and word until the ack edge, then leaves them for the caller
  task automatic send_rx(int r, ring_pkg::ring_word_t w);
    int n;
    rx_req[r] = 1'b1;
    rx_word[r] = w;
    for (n = 0; n < 40 && rx_ack[r] !== 1'b1; n++) step();
    if (n == 40) give_up();
    step();
  endtask

  // Released data lines show the inverse, not the stale word
  task automatic rx_idle(int r);
    rx_req[r] = 1'b0;
    rx_word[r] = ring_pkg::ring_word_t'(~rx_word[r]);
  endtask

  task automatic pass_word(int r, int o, logic [1:0] kind, logic [7:0] dest);
    ring_pkg::ring_word_t w;
    int                   n0, n;
    w = mk(kind, 1'b1, 1'b1, dest, 32'hc0de_0000 + dest);
    n0 = gsz(o);
    send_rx(r, w);
    rx_idle(r);
    for (n = 0; n < 20 && gsz(o) == n0; n++) step();
    `CHK(gsz(o), n0 + 1)
    `CHK(last(o), w)
  endtask

  task automatic send_block(int r, int n, int pend, logic [1:0] kind);
    int k, c, n0;
    n0 = gsz(r);
    up_token_seen[r] = 1'b1;
    txd_pending = 16'(pend);
    txd_valid = 1'b1;
    txd_word = mk(kind, 1'b1, pend == 1, 8'h33, 32'h0000_0000);
    for (c = 0; c < 20 && up_token_hold[r] !== 1'b1; c++) step();
    `CHK(up_token_hold[r], 1'b1)
    for (k = 0; k < n; k++) begin
      txd_word = mk(kind, k == 0, k == n - 1 && pend == n, 8'h33, 32'(k));
      txd_pending = 16'(pend - k);
      for (c = 0; c < 40 && !(txd_ready === 1'b1 && tx_ack[r] === 1'b1); c++) step();
      if (c == 40) give_up();
      step();
    end
    txd_valid = 1'b0;
    txd_pending = 16'(pend - n);
    for (c = 0; c < 20 && txd_done !== 1'b1; c++) step();
    `CHK(txd_done, 1'b1)
    `CHK(up_token_hold[r], 1'b1)
    step();
    `CHK(up_token_hold[r], 1'b0)
    up_token_seen[r] = 1'b0;
    `CHK(gsz(r), n0 + n)
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_forward;
    pass_word(0, 0, ring_pkg::KIND_DATA, 8'h11);
    pass_word(1, 1, ring_pkg::KIND_MAINT, 8'h22);
    loopback_en = 1'b1;
    pass_word(0, 1, ring_pkg::KIND_DATA, 8'h44);
    pass_word(1, 0, ring_pkg::KIND_DATA, 8'h45);
    loopback_en = 1'b0;
  endtask

  task automatic t_receive;
    ring_pkg::ring_word_t w0, w1;
    int                   c;
    rxq.delete();
    ringq.delete();
    batch_sz = 0;
    w0 = mk(ring_pkg::KIND_DATA, 1'b1, 1'b1, ME, 32'h1111_0000);
    w1 = mk(ring_pkg::KIND_DATA, 1'b1, 1'b1, ME, 32'h2222_0000);
    send_rx(0, w0);
    rx_idle(0);
    send_rx(1, w1);
    rx_idle(1);
    for (c = 0; c < 30 && batch_sz == 0; c++) step();
    `CHK(batch_sz, 2)
    `CHK(rxq[0], w0)
    `CHK(rxq[1], w1)
    `CHK(ringq[0], 1'b0)
    `CHK(ringq[1], 1'b1)
  endtask

  task automatic t_quarantine;
    quarantined = 1'b1;
    rxq.delete();
    pass_word(0, 0, ring_pkg::KIND_DATA, ME);
    up_token_seen[0] = 1'b1;
    txd_valid = 1'b1;
    txd_pending = 16'h0001;
    repeat (10) step();
    `CHK(up_token_hold[0], 1'b0)
    `CHK(rxq.size(), 0)
    txd_valid = 1'b0;
    txd_pending = 16'h0000;
    up_token_seen[0] = 1'b0;
    step();
    quarantined = 1'b0;
  endtask

  task automatic t_transmit;
    slow = 1'b1;
    send_block(0, 16, 17, ring_pkg::KIND_DATA);
    slow = 1'b0;
    send_block(0, 1, 1, ring_pkg::KIND_DATA);
    active_ring = 1'b1;
    send_block(1, 2, 2, ring_pkg::KIND_DATA);
    active_ring = 1'b0;
    isolated = 1'b1;
    up_token_seen[0] = 1'b1;
    txd_valid = 1'b1;
    txd_pending = 16'h0001;
    txd_word = mk(ring_pkg::KIND_DATA, 1'b1, 1'b1, 8'h33, 32'h0000_0000);
    repeat (10) step();
    `CHK(up_token_hold[0], 1'b0)
    txd_valid = 1'b0;
    up_token_seen[0] = 1'b0;
    step();
    send_block(0, 1, 1, ring_pkg::KIND_MAINT);
    isolated = 1'b0;
  endtask

  task automatic t_token;
    int c;
    token_track_en = 1'b1;
    lost_token_clr = 1'b1;
    pass_word(0, 0, ring_pkg::KIND_TOKEN, 8'h00);
    lost_token_clr = 1'b0;
    `CHK(token_tracking_flag[0], 1'b1)
    `CHK(lost_token, 1'b0)
    for (c = 0; c < TMO + 20 && lost_token !== 1'b1; c++) step();
    `CHK(c >= TMO - 10 && c <= TMO + 2, 1'b1)
    token_track_en = 1'b0;
    step();
    step();
    `CHK(token_tracking_flag, 2'b00)
  endtask

  initial begin
    rst_n = 1'b0;
    node_addr = ME;
    active_ring = 1'b0;
    quarantined = 1'b0;
    isolated = 1'b0;
    loopback_en = 1'b0;
    token_track_en = 1'b0;
    rx_req = 2'b00;
    rx_word = '0;
    up_token_seen = 2'b00;
    rxd_ready = 1'b1;
    txd_valid = 1'b0;
    txd_word = '0;
    txd_pending = 16'h0000;
    lost_token_clr = 1'b0;
    slow = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    `CHK(up_token_hold, 2'b00)
    t_forward();
    t_receive();
    t_quarantine();
    t_transmit();
    t_token();
    complete_run();
  end
endmodule
